/* inc/ddc_defines.svh */
// Constants for the memory controller write path, calibration bus and pad sequencer
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DDC_AXI_NARROW_W   128
`define DDC_AXI_WIDE_W     256
`define DDC_ID_W           8
`define DDC_MEM_ADDR_W     16
`define DDC_MEM_BANK_W     3
`define DDC_DQ_W           16
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DDC_CLK_PERIOD_NS  100
`define DDC_RST_HOLD_NS    200000
`define DDC_RST_HOLD_CYC   ((`DDC_RST_HOLD_NS + `DDC_CLK_PERIOD_NS - 1) / `DDC_CLK_PERIOD_NS)
`define DDC_CKE_WAIT_NS    500000
`define DDC_CKE_WAIT_CYC   ((`DDC_CKE_WAIT_NS + `DDC_CLK_PERIOD_NS - 1) / `DDC_CLK_PERIOD_NS)
`define DDC_MODE_REG_CNT   4
// ----------------------------------------------------------------
// Commands {cs, ras, cas, we}, all active low
// ----------------------------------------------------------------
`define DDC_CMD_NOP        4'h7
`define DDC_CMD_WRITE      4'h4
`define DDC_CMD_MODE       4'h0
`define DDC_CMD_DESELECT   4'hF
// ----------------------------------------------------------------
// Calibration bus
// ----------------------------------------------------------------
`define DDC_CAL_ADDR       7'h2A
`endif

/* inc/ddc_pkg.sv */
// Types for the memory controller startup sequencer and calibration bus slave
package ddc_pkg;
   // ----------------------------------------------------------------
   // Startup sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      init_idle     = 3'h0,
      init_rst_hold = 3'h1,
      init_cke_wait = 3'h2,
      init_mode_set = 3'h3,
      init_done     = 3'h4
   } ddc_init_state_t;
   // ----------------------------------------------------------------
   // Calibration bus slave states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ser_idle = 3'h0,
      ser_addr = 3'h1,
      ser_ack  = 3'h2,
      ser_data = 3'h3
   } ddc_ser_state_t;
endpackage : ddc_pkg

/* src/ddc_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module ddc_sync #(
   parameter int          W         = 1,
   parameter logic [15:0] RESET_VAL = 16'h0000
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         reset_n,
   // Data
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;   // Metastable stage, read only by stage two

   if (W > 16) begin : g_bad_w
      $error("ddc_sync supports at most 16 bits");
   end

   // Both stages reset to a constant
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         stage1   <= RESET_VAL[W-1:0];
         sync_out <= RESET_VAL[W-1:0];
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : ddc_sync
`default_nettype wire

/* src/ddc_ctrl.sv */
// Memory controller write data ports, calibration bus, startup sequencer and pads
`include "ddc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl #(
   parameter int P0_W          = `DDC_AXI_WIDE_W,
   parameter int DQ_W          = `DDC_DQ_W,
   parameter int CKE_WAIT_CYC  = `DDC_CKE_WAIT_CYC,
   parameter logic [6:0] CAL_ADDR = `DDC_CAL_ADDR
) (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        reset_n,
   input  wire logic                        master_reset_n,
   // Port 0 write data
   input  wire logic [P0_W-1:0]             wr0_data,
   input  wire logic [P0_W/8-1:0]           wr0_strobe,
   input  wire logic [`DDC_ID_W-1:0]        wr0_id,
   input  wire logic                        wr0_last,
   input  wire logic                        wr0_valid,
   output logic                             wr0_ready,
   // Port 1 write data
   input  wire logic [`DDC_AXI_NARROW_W-1:0]   wr1_data,
   input  wire logic [`DDC_AXI_NARROW_W/8-1:0] wr1_strobe,
   input  wire logic [`DDC_ID_W-1:0]        wr1_id,
   input  wire logic                        wr1_last,
   input  wire logic                        wr1_valid,
   output logic                             wr1_ready,
   // Write progress
   output logic                             burst_done,
   output logic [`DDC_ID_W-1:0]             burst_done_id,
   // Calibration serial bus
   input  wire logic                        cal_bus_clock_in,
   input  wire logic                        cal_bus_data_in,
   output logic                             cal_bus_data_drive_en,
   output logic [7:0]                       cal_byte,
   output logic                             cal_byte_valid,
   // Startup sequencer
   input  wire logic                        init_sequencer_reset,
   input  wire logic                        init_sequencer_start,
   output logic                             init_complete,
   // Memory command pads
   output logic [`DDC_MEM_ADDR_W-1:0]       mem_addr,
   output logic [`DDC_MEM_BANK_W-1:0]       mem_bank,
   output logic                             mem_cs_n,
   output logic                             mem_ras_n,
   output logic                             mem_cas_n,
   output logic                             mem_we_n,
   output logic                             mem_clock_enable,
   output logic                             mem_reset_n,
   output logic                             mem_clock_p,
   output logic                             mem_clock_n,
   output logic                             mem_termination_ctrl,
   // Memory data pads
   input  wire logic [DQ_W-1:0]             mem_dq_in,
   output logic [DQ_W-1:0]                  mem_dq_out,
   output logic                             mem_dq_oe,
   input  wire logic [DQ_W/8-1:0]           mem_dqs_in,
   output logic [DQ_W/8-1:0]                mem_dqs_p_out,
   output logic [DQ_W/8-1:0]                mem_dqs_n_out,
   output logic                             mem_dqs_oe,
   output logic [DQ_W/8-1:0]                mem_byte_mask,
   // Impedance calibration pad
   input  wire logic                        mem_impedance_cal_pin_in,
   output logic                             mem_impedance_cal_pin_out,
   output logic                             mem_impedance_cal_pin_oe
);
   // ----------------------------------------------------------------
   // Derived sizes and checks
   // ----------------------------------------------------------------
   localparam int N_W    = `DDC_AXI_NARROW_W;
   localparam int LANES  = DQ_W / 8;
   localparam int CYC0   = P0_W / DQ_W;
   localparam int CYC1   = N_W / DQ_W;
   localparam int RST_HOLD = `DDC_RST_HOLD_CYC;

   if (!(P0_W == N_W || P0_W == `DDC_AXI_WIDE_W)) begin : g_bad_p0
      $error("Port 0 width must be 128 or 256");
   end
   if (!(DQ_W == 8 || DQ_W == 16)) begin : g_bad_dq
      $error("DQ width must be 8 or 16");
   end
   if (CKE_WAIT_CYC < 1 || CKE_WAIT_CYC > 65535) begin : g_bad_cke
      $error("Clock enable wait must fit 16 bits");
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Reset values match each pin's idle level, so no false edge follows reset
   logic [4:0] pins_s;     // {master rst_n, seq rst, seq start, cal clk, cal data}
   ddc_sync #(.W(5), .RESET_VAL(16'h0013)) u_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in ({master_reset_n, init_sequencer_reset, init_sequencer_start,
                  cal_bus_clock_in, cal_bus_data_in}),
      .sync_out (pins_s)
   );

   logic rst;              // Whole-block reset, either source
   assign rst = !reset_n || !pins_s[4];

   // Unused read paths are kept only to present the pad triples
   logic unused_in;
   assign unused_in = ^{mem_dq_in, mem_dqs_in, mem_impedance_cal_pin_in};

   // ----------------------------------------------------------------
   // Memory clock follows the controller clock
   // ----------------------------------------------------------------
   assign mem_clock_p = clock;
   assign mem_clock_n = !clock;
   assign mem_impedance_cal_pin_out = 1'b0;
   assign mem_impedance_cal_pin_oe  = 1'b0;

   // ----------------------------------------------------------------
   // Startup sequencer
   // ----------------------------------------------------------------
   ddc_pkg::ddc_init_state_t init_state;
   logic [15:0] init_cnt;  // Wait counter for reset hold and CKE wait
   logic        start_d;   // Previous start level, for edge finding
   logic        start_edge;
   assign start_edge = pins_s[2] && !start_d;

   // Start edge launches; the sequencer reset pins it in idle
   always_ff @(posedge clock) begin
      if (rst || pins_s[3]) begin
         init_state <= ddc_pkg::init_idle;
         init_cnt   <= 16'h0000;
         start_d    <= 1'b0;
      end else begin
         start_d <= pins_s[2];
         case (init_state)
            ddc_pkg::init_idle: begin
               if (start_edge) begin
                  init_state <= ddc_pkg::init_rst_hold;
                  init_cnt   <= 16'(RST_HOLD - 1);
               end
            end
            ddc_pkg::init_rst_hold: begin
               if (init_cnt == 16'h0000) begin
                  init_state <= ddc_pkg::init_cke_wait;
                  init_cnt   <= 16'(CKE_WAIT_CYC - 1);
               end else begin
                  init_cnt <= init_cnt - 16'h0001;
               end
            end
            ddc_pkg::init_cke_wait: begin
               if (init_cnt == 16'h0000) begin
                  init_state <= ddc_pkg::init_mode_set;
                  init_cnt   <= 16'(`DDC_MODE_REG_CNT - 1);
               end else begin
                  init_cnt <= init_cnt - 16'h0001;
               end
            end
            ddc_pkg::init_mode_set: begin
               // One mode register write per cycle
               if (init_cnt == 16'h0000) begin
                  init_state <= ddc_pkg::init_done;
               end else begin
                  init_cnt <= init_cnt - 16'h0001;
               end
            end
            ddc_pkg::init_done: begin
               // A fresh start reruns the whole sequence
               if (start_edge) begin
                  init_state <= ddc_pkg::init_rst_hold;
                  init_cnt   <= 16'(RST_HOLD - 1);
               end
            end
            default: init_state <= ddc_pkg::init_idle;
         endcase
      end
   end
   assign init_complete = (init_state == ddc_pkg::init_done);

   // ----------------------------------------------------------------
   // Write data holding registers, one beat per port
   // ----------------------------------------------------------------
   logic [P0_W-1:0]      h0_data;
   logic [P0_W/8-1:0]    h0_strb;
   logic [7:0]           h0_id;
   logic                 h0_last;
   logic                 h0_full;
   logic [N_W-1:0]       h1_data;
   logic [N_W/8-1:0]     h1_strb;
   logic [7:0]           h1_id;
   logic                 h1_last;
   logic                 h1_full;
   logic                 take0;       // Engine claims port 0 beat
   logic                 take1;       // Engine claims port 1 beat

   // Ready only with an empty slot and memory initialised; stalls until rerun
   assign wr0_ready = !h0_full && init_complete;
   assign wr1_ready = !h1_full && init_complete;

   // Capture on valid and ready; the ID and last travel with the data
   always_ff @(posedge clock) begin
      if (rst) begin
         h0_full <= 1'b0;
         h1_full <= 1'b0;
      end else begin
         if (wr0_valid && wr0_ready) begin
            h0_data <= wr0_data;
            h0_strb <= wr0_strobe;
            h0_id   <= wr0_id;
            h0_last <= wr0_last;
            h0_full <= 1'b1;
         end else if (take0) begin
            h0_full <= 1'b0;
         end
         if (wr1_valid && wr1_ready) begin
            h1_data <= wr1_data;
            h1_strb <= wr1_strobe;
            h1_id   <= wr1_id;
            h1_last <= wr1_last;
            h1_full <= 1'b1;
         end else if (take1) begin
            h1_full <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Write engine: serialises a beat onto the data pads
   // ----------------------------------------------------------------
   logic                 busy;        // Beat on the pads
   logic                 last_p0;     // Fairness: port 0 served last
   logic [5:0]           beat_cnt;    // Data cycles still to go
   logic [P0_W-1:0]      shift_data;
   logic [P0_W/8-1:0]    shift_strb;
   logic [7:0]           cur_id;
   logic                 cur_last;
   logic [15:0]          col;         // Running column address

   // Alternate between ports when both wait, so neither starves
   assign take0 = !busy && init_complete && h0_full && (!h1_full || !last_p0);
   assign take1 = !busy && init_complete && h1_full && !take0;

   always_ff @(posedge clock) begin
      if (rst) begin
         busy          <= 1'b0;
         last_p0       <= 1'b0;
         beat_cnt      <= 6'h00;
         col           <= 16'h0000;
         burst_done    <= 1'b0;
         burst_done_id <= 8'h00;
      end else begin
         burst_done <= 1'b0;
         if (take0) begin
            busy       <= 1'b1;
            last_p0    <= 1'b1;
            beat_cnt   <= 6'(CYC0);
            shift_data <= h0_data;
            shift_strb <= h0_strb;
            cur_id     <= h0_id;
            cur_last   <= h0_last;
         end else if (take1) begin
            busy       <= 1'b1;
            last_p0    <= 1'b0;
            beat_cnt   <= 6'(CYC1);
            shift_data <= P0_W'(h1_data);
            shift_strb <= (P0_W/8)'(h1_strb);
            cur_id     <= h1_id;
            cur_last   <= h1_last;
         end else if (busy) begin
            shift_data <= shift_data >> DQ_W;
            shift_strb <= shift_strb >> LANES;
            beat_cnt   <= beat_cnt - 6'h01;
            if (beat_cnt == 6'h01) begin
               busy <= 1'b0;
               col  <= col + 16'h0001;
               // Report the burst end when its final beat leaves
               burst_done    <= cur_last;
               burst_done_id <= cur_id;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Pad drivers, all from flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDC_CMD_DESELECT;
         mem_addr             <= 16'h0000;
         mem_bank             <= 3'h0;
         mem_reset_n          <= 1'b0;
         mem_clock_enable     <= 1'b0;
         mem_termination_ctrl <= 1'b0;
         mem_dq_out           <= '0;
         mem_dq_oe            <= 1'b0;
         mem_dqs_p_out        <= '0;
         mem_dqs_n_out        <= '1;
         mem_dqs_oe           <= 1'b0;
         mem_byte_mask        <= '0;
      end else begin
         // Memory reset released after the hold; CKE after the wait
         mem_reset_n      <= (init_state != ddc_pkg::init_idle) &&
                             (init_state != ddc_pkg::init_rst_hold);
         mem_clock_enable <= (init_state == ddc_pkg::init_mode_set) ||
                             (init_state == ddc_pkg::init_done);
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDC_CMD_NOP;
         if (init_state == ddc_pkg::init_mode_set) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDC_CMD_MODE;
            mem_bank <= init_cnt[2:0];
            mem_addr <= 16'h0000;
         end else if (take0 || take1) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DDC_CMD_WRITE;
            mem_addr <= col;
            mem_bank <= take0 ? h0_id[2:0] : h1_id[2:0];
         end
         // Data, strobes, mask and termination while a beat is out
         mem_termination_ctrl <= busy;
         mem_dq_oe            <= busy;
         mem_dqs_oe           <= busy;
         mem_dq_out           <= shift_data[DQ_W-1:0];
         mem_byte_mask        <= busy ? ~shift_strb[LANES-1:0] : '0;
         mem_dqs_p_out        <= busy ? ~mem_dqs_p_out : '0;
         mem_dqs_n_out        <= busy ? mem_dqs_p_out : '1;
      end
   end

   // ----------------------------------------------------------------
   // Calibration bus slave, write-only
   // ----------------------------------------------------------------
   // Limitation: read transfers are acknowledged but return nothing.
   ddc_pkg::ddc_ser_state_t ser_state;
   logic       scl_d;
   logic       sda_d;
   logic [3:0] bit_cnt;
   logic [7:0] ser_shift;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   assign scl_rise   = pins_s[1] && !scl_d;
   assign scl_fall   = !pins_s[1] && scl_d;
   assign start_cond = pins_s[1] && scl_d && sda_d && !pins_s[0];
   assign stop_cond  = pins_s[1] && scl_d && !sda_d && pins_s[0];

   // Samples on clock rise, drives acknowledge by enabling the low pull
   always_ff @(posedge clock) begin
      if (rst) begin
         ser_state             <= ddc_pkg::ser_idle;
         scl_d                 <= 1'b1;
         sda_d                 <= 1'b1;
         bit_cnt               <= 4'h0;
         ser_shift             <= 8'h00;
         cal_bus_data_drive_en <= 1'b0;
         cal_byte              <= 8'h00;
         cal_byte_valid        <= 1'b0;
      end else begin
         scl_d          <= pins_s[1];
         sda_d          <= pins_s[0];
         cal_byte_valid <= 1'b0;
         if (start_cond) begin
            ser_state             <= ddc_pkg::ser_addr;
            bit_cnt               <= 4'h0;
            cal_bus_data_drive_en <= 1'b0;
         end else if (stop_cond) begin
            ser_state             <= ddc_pkg::ser_idle;
            cal_bus_data_drive_en <= 1'b0;
         end else begin
            case (ser_state)
               ddc_pkg::ser_addr, ddc_pkg::ser_data: begin
                  if (scl_rise && bit_cnt != 4'h8) begin
                     ser_shift <= {ser_shift[6:0], pins_s[0]};
                     bit_cnt   <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     if (ser_state == ddc_pkg::ser_data) begin
                        cal_byte       <= ser_shift;
                        cal_byte_valid <= 1'b1;
                        cal_bus_data_drive_en <= 1'b1;
                        ser_state      <= ddc_pkg::ser_ack;
                     end else if (ser_shift[7:1] == CAL_ADDR) begin
                        cal_bus_data_drive_en <= 1'b1;
                        ser_state      <= ddc_pkg::ser_ack;
                     end else begin
                        ser_state <= ddc_pkg::ser_idle;
                     end
                  end
               end
               ddc_pkg::ser_ack: begin
                  // Release the line after the acknowledge clock
                  if (scl_fall) begin
                     cal_bus_data_drive_en <= 1'b0;
                     bit_cnt   <= 4'h0;
                     ser_state <= ddc_pkg::ser_data;
                  end
               end
               default: ser_state <= ddc_pkg::ser_idle;
            endcase
         end
      end
   end
endmodule : ddc_ctrl
`default_nettype wire

/* verification/ddc_properties.sv */
// Checker for write handshake, sequencer and memory pad behaviour
`timescale 1ns/1ps
`default_nettype none
module ddc_properties (
   input wire logic clock, reset_n, wr0_valid, wr0_ready, wr1_ready, init_complete,
   input wire logic init_sequencer_reset, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n,
   input wire logic mem_clock_enable, mem_reset_n, mem_clock_p, mem_clock_n,
   input wire logic mem_dq_oe, mem_termination_ctrl
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // A beat taken fills the single holding slot
   sequence s_take; wr0_valid && wr0_ready; endsequence
   a_ready_after_init: assert property (wr0_ready |-> init_complete)
      else $error("port 0 ready before init");
   a_port1_gated: assert property (wr1_ready |-> init_complete)
      else $error("port 1 ready before init");
   a_slot_full: assert property (s_take |=> !wr0_ready)
      else $error("ready held after beat");
   // Synchroniser needs a few cycles before the hold shows
   a_seq_reset_idle: assert property (init_sequencer_reset [*4] |-> !init_complete)
      else $error("sequencer reset ignored");
   a_clock_pair: assert property (mem_clock_n != mem_clock_p)
      else $error("memory clock pair not complementary");
   a_cke_in_reset: assert property (!mem_reset_n |-> !mem_clock_enable)
      else $error("clock enable high in memory reset");
   a_odt_with_dq: assert property (mem_dq_oe |-> mem_termination_ctrl)
      else $error("termination off while driving");
   a_write_cmd: assert property ($rose(mem_dq_oe) |->
      $past({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}) == 4'h4)
      else $error("data driven without write command");
   a_done_pads_on: assert property (init_complete |-> mem_reset_n && mem_clock_enable)
      else $error("memory held in reset after init");
endmodule : ddc_properties
bind ddc_ctrl ddc_properties chk_i (.*);
`default_nettype wire

/* verification/ddc_mem_model.sv */
// Memory side model: captures driven data words
`timescale 1ns/1ps
`default_nettype none
module ddc_mem_model (
   input wire logic clock, mem_dq_oe,
   input wire logic [15:0] mem_dq_out,
   output logic [15:0] mem_dq_in, first,
   output logic [1:0] mem_dqs_in,
   output int words
);
   logic oe_q = 1'b0;
   // Released lines never show the last value: the simulator would pick it for us
   assign mem_dq_in  = ~mem_dq_out;
   assign mem_dqs_in = {2{~clock}};
   // Count words of the newest burst and keep the first one
   always @(posedge clock) begin
      oe_q <= mem_dq_oe;
      if (mem_dq_oe && !oe_q) begin
         words <= 1;
         first <= mem_dq_out;
      end else if (mem_dq_oe) words <= words + 1;
   end
endmodule : ddc_mem_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the controller write path and configuration logic
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock = 0, reset_n = 0, master_reset_n = 1, v0 = 0, v1 = 0, last = 1;
   logic scl = 1, sda = 1, seq_rst = 0, seq_go = 0, dren, ic, oe, burst_done, mrst;
   logic wr0_ready, wr1_ready;
   logic [255:0] d = '0;
   logic [31:0] st = '1;
   logic [15:0] dqi, dqo, first;
   logic [7:0] id = '0, bid, cb;
   logic [1:0] dqsi;
   logic cbv;
   int words, n, ncb = 0, fail_count = 0, total_checks = 0;
   always #50 clock = ~clock;
   ddc_ctrl #(.CKE_WAIT_CYC(10)) DUT (.clock, .reset_n, .master_reset_n, .wr0_data(d),
      .wr0_strobe(st), .wr0_id(id), .wr0_last(last), .wr0_valid(v0), .wr0_ready,
      .wr1_data(d[127:0]), .wr1_strobe(st[15:0]), .wr1_id(id), .wr1_last(last),
      .wr1_valid(v1), .wr1_ready, .burst_done, .burst_done_id(bid), .cal_bus_clock_in(scl),
      .cal_bus_data_in(sda & !dren), .cal_bus_data_drive_en(dren), .cal_byte(cb),
      .cal_byte_valid(cbv), .init_sequencer_reset(seq_rst), .init_sequencer_start(seq_go),
      .init_complete(ic), .mem_addr(), .mem_bank(), .mem_cs_n(), .mem_ras_n(), .mem_cas_n(),
      .mem_we_n(), .mem_clock_enable(), .mem_reset_n(mrst), .mem_clock_p(), .mem_clock_n(),
      .mem_termination_ctrl(), .mem_dq_in(dqi), .mem_dq_out(dqo), .mem_dq_oe(oe),
      .mem_dqs_in(dqsi), .mem_dqs_p_out(), .mem_dqs_n_out(), .mem_dqs_oe(), .mem_byte_mask(),
      .mem_impedance_cal_pin_in(1'b1), .mem_impedance_cal_pin_out(), .mem_impedance_cal_pin_oe());
   ddc_mem_model mem (.clock, .mem_dq_oe(oe), .mem_dq_out(dqo), .mem_dq_in(dqi), .first,
      .mem_dqs_in(dqsi), .words);
   // Count received calibration data bytes
   always @(posedge clock) if (cbv === 1'b1) ncb <= ncb + 1;
   task chk(input logic [255:0] got, input logic [255:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wrap_up;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   // One serial byte, MSB first, then the acknowledge slot; wire pulled up when released
   task ser(input logic [7:0] b);
      for (int i = 7; i >= -1; i--) begin
         sda <= (i < 0) ? 1'b1 : b[i];
         repeat (2) @(posedge clock); scl <= 1;
         repeat (3) @(posedge clock);
         if (i < 0) chk(dren, 1);
         @(posedge clock); scl <= 0;
         repeat (2) @(posedge clock);
      end
   endtask : ser
   initial begin
      #800000;
      fail_count++;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge clock); reset_n <= 1;
      repeat (4) @(posedge clock); chk(wr0_ready, 0);
      seq_go <= 1; repeat (4) @(posedge clock); seq_go <= 0;
      n = 0; while (!ic && n < 3000) begin @(negedge clock); n++; end
      chk(ic, 1);
      $display("sequencer test done");
      for (int p = 0; p < 2; p++) begin
         @(posedge clock); d <= {128{p[1:0] + 2'h1}}; id <= 8'h11 + p[7:0];
         if (p == 0) v0 <= 1; else v1 <= 1;
         n = 0; do begin @(negedge clock); n++; end
         while (!(p ? wr1_ready : wr0_ready) && n < 99);
         @(posedge clock); v0 <= 0; v1 <= 0;
         n = 0; while (!burst_done && n < 99) begin @(negedge clock); n++; end
         @(negedge clock); // The final word is counted one edge after the done pulse
         chk(bid, 8'h11 + p[7:0]);
         chk(words, p ? 8 : 16);
         chk(first, p ? 16'hAAAA : 16'h5555);
         $display("write port %0d test done", p);
      end
      repeat (2) @(posedge clock); sda <= 0; repeat (4) @(posedge clock); scl <= 0;
      ser(8'h54); ser(8'h5A);
      @(posedge clock); sda <= 0; scl <= 1; repeat (4) @(posedge clock); sda <= 1;
      chk(cb, 8'h5A);
      chk(ncb, 1);
      $display("calibration bus test done");
      seq_rst <= 1; repeat (6) @(posedge clock); chk(ic, 0);
      seq_rst <= 0; repeat (4) @(posedge clock); seq_go <= 1;
      repeat (4) @(posedge clock); seq_go <= 0;
      n = 0; while (!ic && n < 3000) begin @(negedge clock); n++; end
      chk(ic, 1);
      @(posedge clock); master_reset_n <= 0; repeat (6) @(posedge clock);
      chk(wr0_ready, 0);
      chk(mrst, 0);
      chk(ic, 0);
      master_reset_n <= 1; repeat (6) @(posedge clock);
      chk(wr0_ready, 0);
      $display("reset test done");
      wrap_up;
   end
endmodule : tb
`default_nettype wire
